/* common/swwd_pkg.sv */
// Purpose : Shared constants and types for the sleep and watchdog control block
// Assumes : 32-bit APB data, one register per aligned word
// Notes   : Offsets, fields, reset values and counts live here only
package swwd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_STATUS   = 8'h00;
  localparam logic [7:0]  ADDR_WDCTL    = 8'h04;
  localparam logic [7:0]  ADDR_CFG      = 8'h08;
  localparam logic [7:0]  ADDR_CMD      = 8'h0C;

  localparam int          STAT_TO_BIT   = 4;
  localparam int          STAT_PD_BIT   = 3;
  localparam int          WDCTL_PS_LSB  = 1;
  localparam int          WDCTL_SWEN    = 0;
  localparam int          CFG_MODE_LSB  = 0;
  localparam int          CFG_OSCM_LSB  = 2;
  localparam int          CFG_GIE_BIT   = 4;
  localparam int          CMD_SLEEP_BIT = 0;
  localparam int          CMD_CLRWD_BIT = 1;

  localparam logic [4:0]  PS_RESET      = 5'h0B;
  localparam logic [4:0]  PS_MAX_CODE   = 5'h12;
  localparam int          PS_MIN_SHIFT  = 5;
  localparam int          CNT_W         = 23;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          OST_PERIODS   = 1024;
  localparam int          OST_W         = 11;
  localparam logic [15:0] ISR_VECTOR    = 16'h0004;

  typedef enum logic [1:0] {
    MODE_ALWAYS_OFF = 2'b00,
    MODE_SOFTWARE   = 2'b01,
    MODE_OFF_SLEEP  = 2'b10,
    MODE_ALWAYS_ON  = 2'b11
  } swwd_mode_e;

  typedef enum logic [1:0] {
    OSC_INTERNAL = 2'b00,
    OSC_XTAL_MED = 2'b01,
    OSC_XTAL_HS  = 2'b10,
    OSC_XTAL_LP  = 2'b11
  } swwd_osc_e;

  // Gray order along awake, sleep, start-up, resume
  typedef enum logic [1:0] {
    ST_AWAKE  = 2'b00,
    ST_SLEEP  = 2'b01,
    ST_OST    = 2'b11,
    ST_RESUME = 2'b10
  } swwd_state_e;

  // Last count before time-out; reserved codes give the shortest period
  function automatic logic [CNT_W-1:0] swwd_terminal(input logic [4:0] code);
    logic [CNT_W:0] one_hot;
    one_hot = '0;
    if (code > PS_MAX_CODE)
      one_hot[PS_MIN_SHIFT] = 1'b1;
    else
      one_hot[code + 5'(PS_MIN_SHIFT)] = 1'b1;
    return CNT_W'(one_hot - 1'b1);
  endfunction

endpackage

/* design/swwd_wdt_counter.sv */
// Purpose : Prescaled watchdog counter with selectable terminal count
// Assumes : lfo_tick is a one-cycle pulse per low-frequency oscillator period
// Notes   : Clear and inactive both hold the count at zero
`timescale 1ns/10ps
`default_nettype none
module swwd_wdt_counter
  import swwd_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             lfo_tick,
  input  wire logic             active,
  input  wire logic             clear,
  input  wire logic [4:0]       period_sel,
  output logic                  timeout,
  output logic      [CNT_W-1:0] count
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tmo;
  } swwd_cnt_s;

  swwd_cnt_s cnt_reg;
  swwd_cnt_s cnt_next;

  always_comb
  begin
    cnt_next     = cnt_reg;
    cnt_next.tmo = 1'b0;
    if (clear || !active)
      cnt_next.cnt = '0;
    else if (lfo_tick)
    begin
      if (cnt_reg.cnt == swwd_terminal(period_sel))
      begin
        cnt_next.cnt = '0;
        cnt_next.tmo = 1'b1;
      end
      else
        cnt_next.cnt = cnt_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

  assign timeout = cnt_reg.tmo;
  assign count   = cnt_reg.cnt;

endmodule // swwd_wdt_counter
`default_nettype wire

/* design/swwd_ost_timer.sv */
// Purpose : Oscillator start-up delay after wake in crystal modes
// Assumes : osc_tick pulses once per oscillator period
// Notes   : done pulses one cycle when the delay ends
`timescale 1ns/10ps
`default_nettype none
module swwd_ost_timer
  import swwd_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic osc_tick,
  output logic      running,
  output logic      done
);

  typedef struct packed {
    logic [OST_W-1:0] cnt;
    logic             run;
    logic             fin;
  } swwd_ost_s;

  swwd_ost_s ost_reg;
  swwd_ost_s ost_next;

  always_comb
  begin
    ost_next     = ost_reg;
    ost_next.fin = 1'b0;
    if (start)
    begin
      ost_next.run = 1'b1;
      ost_next.cnt = '0;
    end
    else if (ost_reg.run && osc_tick)
    begin
      if (ost_reg.cnt == OST_W'(OST_PERIODS - 1))
      begin
        ost_next.run = 1'b0;
        ost_next.fin = 1'b1;
      end
      else
        ost_next.cnt = ost_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ost_reg <= '0;
    else
      ost_reg <= ost_next;
  end

  assign running = ost_reg.run;
  assign done    = ost_reg.fin;

endmodule // swwd_ost_timer
`default_nettype wire

/* design/swwd_ctrl.sv */
// Purpose : Sleep entry and exit control with a watchdog timer, APB registers
// Assumes : rst gathers power-on, brown-out and reset-pin sources
// Notes   : Processor events arrive as APB command writes
// Operation
// - Sleep is entered only by the sleep instruction.
// - Sleep entry clears the watchdog; it keeps counting if enabled in sleep.
// - Sleep entry clears the power-down flag and sets the time-out flag.
// - In sleep the processor clock stops; low-frequency oscillators keep running.
// - Pins hold their drive state through sleep.
// - Sleep changes no reset source except the watchdog.
// - Reset sources reset; watchdog and interrupts wake and continue.
// - An enabled interrupt wakes regardless of global interrupt enable.
// - After interrupt wake, vector to 0004h only if global enable set.
// - Sleep prefetches the next instruction, executed first after wake.
// - Any wake clears the watchdog.
// - Pending interrupt with global enable off makes sleep a no-operation.
// - Interrupt during or after sleep: sleep completes then wakes at once.
// - Crystal modes wait 1024 oscillator periods after wake.
// - Watchdog counts on the 31 kHz oscillator, not the processor clock.
// - Mode 11 keeps the watchdog active always.
// - Mode 10 keeps it active awake, disabled asleep.
// - Mode 01 follows the software enable; mode 00 disables it.
// - Period select spans 1 ms to 256 s; reset gives 2 s.
// - Watchdog clears on reset, clear, sleep, wake, oscillator fail, disable, start-up.
// - Watchdog time-out in sleep wakes instead of resetting, updates flags.
// - Period codes double from 1:32; reset code 01011 gives 1:65536.
`timescale 1ns/10ps
`default_nettype none
module swwd_ctrl
  import swwd_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        lfo_tick,
  input  wire logic        osc_tick,
  input  wire logic        osc_fail,
  input  wire logic [7:0]  irq_flags,
  input  wire logic [7:0]  irq_enables,
  output logic             cpu_clk_en,
  output logic             lfo_run,
  output logic             io_hold,
  output logic             sleeping,
  output logic             prefetch_next,
  output logic             resume_exec,
  output logic             isr_call,
  output logic      [15:0] isr_addr,
  output logic             wdt_reset_req
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    swwd_state_e state;
    logic        to_flag;
    logic        pd_flag;
    logic [4:0]  period;
    logic        swen;
    swwd_mode_e  mode;
    swwd_osc_e   oscm;
    logic        global_interrupt_enable;
    logic        wake_int;
    logic        prefetch;
    logic        resume;
    logic        isr;
    logic        wdrst;
    logic [31:0] rdata;
  } swwd_ctrl_s;

  swwd_ctrl_s  ctl_reg;
  swwd_ctrl_s  ctl_next;

  logic             wr_en;
  logic             rd_en;
  logic             addr_ok;
  logic             sleep_cmd;
  logic             clr_cmd;
  logic             irq_pending;
  logic             sleep_go;
  logic             sleep_nop;
  logic             wake_go;
  logic             xtal_mode;
  logic             wdt_active;
  logic             wdt_clear;
  logic             wdt_timeout;
  logic [CNT_W-1:0] wdt_count;
  logic             ost_running;
  logic             ost_done;
  logic             ost_start;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign addr_ok = (paddr == ADDR_STATUS) || (paddr == ADDR_WDCTL) ||
                   (paddr == ADDR_CFG) || (paddr == ADDR_CMD);
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = ctl_reg.rdata;

  // only the sleep command starts sleep
  assign sleep_cmd = wr_en && (paddr == ADDR_CMD) && pwdata[CMD_SLEEP_BIT];
  assign clr_cmd   = wr_en && (paddr == ADDR_CMD) && pwdata[CMD_CLRWD_BIT];

  // wake needs only the individual enable
  assign irq_pending = |(irq_flags & irq_enables);

  // pending interrupt with global enable off turns sleep into a no-op
  assign sleep_nop = sleep_cmd && (ctl_reg.state == ST_AWAKE) &&
                     irq_pending && !ctl_reg.global_interrupt_enable;
  // A time-out already due wins over sleep, so its reset is never lost
  assign sleep_go  = sleep_cmd && (ctl_reg.state == ST_AWAKE) && !sleep_nop &&
                     !wdt_timeout;

  // interrupt during sleep wakes on the next cycle
  // watchdog time-out in sleep wakes rather than resets
  assign wake_go = (ctl_reg.state == ST_SLEEP) && (irq_pending || wdt_timeout);

  assign xtal_mode = (ctl_reg.oscm != OSC_INTERNAL);
  assign ost_start = wake_go && xtal_mode;

  // ----------------------------------------------------------------
  // Watchdog mode
  // ----------------------------------------------------------------
  always_comb
  begin
    case (ctl_reg.mode)
      MODE_ALWAYS_ON: wdt_active = 1'b1;
      MODE_OFF_SLEEP: wdt_active = (ctl_reg.state == ST_AWAKE) ||
                                   (ctl_reg.state == ST_RESUME);
      MODE_SOFTWARE:  wdt_active = ctl_reg.swen;
      default:        wdt_active = 1'b0;
    endcase
  end

  assign wdt_clear = clr_cmd || osc_fail || sleep_go || wake_go || ost_running;

  // counts only on low-frequency oscillator ticks
  swwd_wdt_counter u_wdt
  (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .lfo_tick   (lfo_tick),
    .active     (wdt_active),
    .clear      (wdt_clear),
    .period_sel (ctl_reg.period),
    .timeout    (wdt_timeout),
    .count      (wdt_count)
  );

  swwd_ost_timer u_ost
  (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .start    (ost_start),
    .osc_tick (osc_tick),
    .running  (ost_running),
    .done     (ost_done)
  );

  // ----------------------------------------------------------------
  // Control and registers
  // ----------------------------------------------------------------
  always_comb
  begin
    ctl_next          = ctl_reg;
    ctl_next.prefetch = 1'b0;
    ctl_next.resume   = 1'b0;
    ctl_next.isr      = 1'b0;
    ctl_next.wdrst    = 1'b0;

    if (wr_en && (paddr == ADDR_WDCTL))
    begin
      ctl_next.period = pwdata[WDCTL_PS_LSB +: 5];
      ctl_next.swen   = pwdata[WDCTL_SWEN];
    end
    if (wr_en && (paddr == ADDR_CFG))
    begin
      ctl_next.mode = swwd_mode_e'(pwdata[CFG_MODE_LSB +: 2]);
      ctl_next.oscm = swwd_osc_e'(pwdata[CFG_OSCM_LSB +: 2]);
      ctl_next.global_interrupt_enable  = pwdata[CFG_GIE_BIT];
    end

    if (clr_cmd)
    begin
      ctl_next.to_flag = 1'b1;
      ctl_next.pd_flag = 1'b1;
    end

    case (ctl_reg.state)
      ST_AWAKE:
      begin
        if (sleep_go)
        begin
          ctl_next.to_flag  = 1'b1;
          ctl_next.pd_flag  = 1'b0;
          ctl_next.prefetch = 1'b1;
          ctl_next.state    = ST_SLEEP;
        end
        else if (wdt_timeout)
        begin
          // missed clear gives a reset request
          ctl_next.wdrst   = 1'b1;
          ctl_next.to_flag = 1'b0;
        end
      end
      ST_SLEEP:
      begin
        if (wake_go)
        begin
          ctl_next.wake_int = irq_pending;
          if (!irq_pending)
          begin
            ctl_next.to_flag = 1'b0;
            ctl_next.pd_flag = 1'b0;
          end
          ctl_next.state = xtal_mode ? ST_OST : ST_RESUME;
        end
      end
      ST_OST:
      begin
        if (ost_done)
          ctl_next.state = ST_RESUME;
      end
      default:
      begin
        // resume and, if enabled, vector pulse together in the same cycle
        ctl_next.resume = 1'b1;
        ctl_next.isr    = ctl_reg.wake_int && ctl_reg.global_interrupt_enable;
        ctl_next.state  = ST_AWAKE;
      end
    endcase

    if (rd_en)
    begin
      ctl_next.rdata = '0;
      if (paddr == ADDR_STATUS)
      begin
        ctl_next.rdata[STAT_TO_BIT] = ctl_reg.to_flag;
        ctl_next.rdata[STAT_PD_BIT] = ctl_reg.pd_flag;
      end
      else if (paddr == ADDR_WDCTL)
      begin
        ctl_next.rdata[WDCTL_PS_LSB +: 5] = ctl_reg.period;
        ctl_next.rdata[WDCTL_SWEN]        = ctl_reg.swen;
      end
      else if (paddr == ADDR_CFG)
      begin
        ctl_next.rdata[CFG_MODE_LSB +: 2] = ctl_reg.mode;
        ctl_next.rdata[CFG_OSCM_LSB +: 2] = ctl_reg.oscm;
        ctl_next.rdata[CFG_GIE_BIT]       = ctl_reg.global_interrupt_enable;
      end
    end
  end

  // only rst resets this block; sleep does not mask it
  // reset restores the 2 s period
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctl_reg         <= '0;
      ctl_reg.state   <= ST_AWAKE;
      ctl_reg.to_flag <= 1'b1;
      ctl_reg.pd_flag <= 1'b1;
      ctl_reg.period  <= PS_RESET;
      ctl_reg.mode    <= MODE_ALWAYS_OFF;
      ctl_reg.oscm    <= OSC_INTERNAL;
    end
    else
      ctl_reg <= ctl_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // processor clock gated outside the awake states
  assign cpu_clk_en    = (ctl_reg.state == ST_AWAKE) || (ctl_reg.state == ST_RESUME);
  assign lfo_run       = 1'b1;
  // pin drive frozen while the core is stopped
  assign io_hold       = !cpu_clk_en;
  assign sleeping      = (ctl_reg.state == ST_SLEEP);
  assign prefetch_next = ctl_reg.prefetch;
  assign resume_exec   = ctl_reg.resume;
  assign isr_call      = ctl_reg.isr;
  assign isr_addr      = ISR_VECTOR;
  assign wdt_reset_req = ctl_reg.wdrst;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_sleep_flags: assert property (sleep_go |=> sleeping && ctl_reg.to_flag && !ctl_reg.pd_flag)
    else $error("sleep entry flags wrong");

  a_sleep_nop: assert property (sleep_nop |=> !sleeping && $stable(ctl_reg.pd_flag))
    else $error("nop sleep changed state");

  a_wdt_clr_entry: assert property (sleep_go |=> wdt_count == '0)
    else $error("watchdog not cleared on sleep");

  a_wake_clear: assert property (wake_go |=> wdt_count == '0 && !sleeping)
    else $error("watchdog not cleared on wake");

  a_clock_gated: assert property (sleeping |-> !cpu_clk_en && io_hold)
    else $error("clock running in sleep");

  a_mode_off: assert property (ctl_reg.mode == MODE_ALWAYS_OFF |=> wdt_count == '0)
    else $error("watchdog counting while off");

  a_ost_hold: assert property (ost_running |=> wdt_count == '0)
    else $error("watchdog counting during start-up");

  a_awake_reset: assert property (!sleeping && wdt_timeout && ctl_reg.state == ST_AWAKE
                                   && !sleep_go |=> wdt_reset_req)
    else $error("missing watchdog reset");

  a_isr_gated: assert property (isr_call |-> $past(ctl_reg.global_interrupt_enable, 1))
    else $error("vector without global enable");

  c_int_wake: cover property (sleep_go ##[1:20] (wake_go && irq_pending));
  c_wdt_wake: cover property (sleeping && wdt_timeout);
  c_nop: cover property (sleep_nop);
  c_awake_reset: cover property (wdt_reset_req);

endmodule // swwd_ctrl
`default_nettype wire

/* testbench/swwd_fw_model.sv */
// Purpose : Far-side model: oscillator ticks and interrupt sources
// Assumes : One sys_clk domain; ticks are one-cycle pulses
// Notes   : Low-frequency rate is scaled down to keep runs short
`timescale 1ns/10ps
`default_nettype none
module swwd_fw_model
#(
  parameter int LFO_DIV = 2
)
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       irq_req,
  output logic            lfo_tick,
  output logic            osc_tick,
  output logic      [7:0] irq_flags,
  output logic      [7:0] irq_enables
);
  int div_cnt = 0;

  // free-running time base, unaffected by sleep or reset
  always_ff @(posedge sys_clk)
  begin
    div_cnt  <= (div_cnt >= LFO_DIV - 1) ? 0 : div_cnt + 1;
    lfo_tick <= (div_cnt == LFO_DIV - 1);
  end

  // crystal ticks every cycle so the start-up count is visible
  assign osc_tick    = 1'b1;
  // source 5 keeps its flag up without enable and must never wake
  assign irq_enables = 8'h04;
  assign irq_flags   = {2'b00, 1'b1, 2'b00, irq_req, 2'b00};
endmodule // swwd_fw_model
`default_nettype wire

/* testbench/swwd_ctrl_tb_top.sv */
// Purpose : Self-checking bench for the sleep and watchdog control block
// Assumes : Firmware acts through APB command writes
// Notes   : Watchdog period code 0 gives 32 ticks, one tick per 2 cycles
`timescale 1ns/10ps
`default_nettype none
module swwd_ctrl_tb_top
  import swwd_pkg::*;
;
  localparam logic [31:0] TO_M = 32'h1 << STAT_TO_BIT;
  localparam logic [31:0] PD_M = 32'h1 << STAT_PD_BIT;
  localparam logic [31:0] SLP  = 32'h1 << CMD_SLEEP_BIT;
  localparam logic [31:0] CLR  = 32'h1 << CMD_CLRWD_BIT;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        lfo_tick, osc_tick, osc_fail, irq_req;
  logic        cpu_clk_en, lfo_run, io_hold, sleeping, prefetch_next;
  logic        resume_exec, isr_call, wdt_reset_req, rd_err;
  logic [7:0]  paddr, irq_flags, irq_enables;
  logic [15:0] isr_addr;
  logic [31:0] pwdata, prdata, rd_data;
  int          miscompares = 0;
  int          num_checks = 0;
  int          n;

  swwd_ctrl dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .lfo_tick(lfo_tick), .osc_tick(osc_tick), .osc_fail(osc_fail),
    .irq_flags(irq_flags), .irq_enables(irq_enables), .cpu_clk_en(cpu_clk_en),
    .lfo_run(lfo_run), .io_hold(io_hold), .sleeping(sleeping),
    .prefetch_next(prefetch_next), .resume_exec(resume_exec), .isr_call(isr_call),
    .isr_addr(isr_addr), .wdt_reset_req(wdt_reset_req));

  swwd_fw_model #(.LFO_DIV(2)) fw (.sys_clk(sys_clk), .rst(rst), .irq_req(irq_req),
    .lfo_tick(lfo_tick), .osc_tick(osc_tick), .irq_flags(irq_flags),
    .irq_enables(irq_enables));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd_data);
  endtask

  // Bounded wait for a wake resume or a watchdog reset request
  task automatic wait_evt(input bit rq, input int lim, output int cnt);
    cnt = 0;
    while (cnt < lim && ((rq ? wdt_reset_req : resume_exec) !== 1'b1))
    begin
      @(posedge sys_clk);
      cnt++;
    end
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdchk("status", ADDR_STATUS, TO_M | PD_M);
    rdchk("wdctl", ADDR_WDCTL, 32'(PS_RESET) << WDCTL_PS_LSB);
    rdchk("cfg", ADDR_CFG, 32'h0);
    rdchk("cmd", ADDR_CMD, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, 32'(rd_err));
    chk("isr_addr", 32'(ISR_VECTOR), 32'(isr_addr));
    $display("test reset done");
  endtask

  task automatic t_irq_wake();
    apb(1'b1, ADDR_CFG, 32'h1 << CFG_GIE_BIT);
    apb(1'b1, ADDR_CMD, SLP);
    @(posedge sys_clk);
    chk("sleeping", 32'h1, 32'(sleeping));
    chk("prefetch", 32'h1, 32'(prefetch_next));
    chk("clk_en", 32'h0, 32'(cpu_clk_en));
    chk("lfo_run", 32'h1, 32'(lfo_run));
    chk("io_hold", 32'h1, 32'(io_hold));
    repeat (20) @(posedge sys_clk);
    chk("still asleep", 32'h1, 32'(sleeping));
    irq_req <= 1'b1;
    wait_evt(1'b0, 100, n);
    chk("isr_call", 32'h1, 32'(isr_call));
    irq_req <= 1'b0;
    rdchk("status", ADDR_STATUS, TO_M);
    $display("test irq_wake done");
  endtask

  task automatic t_nop();
    apb(1'b1, ADDR_CFG, 32'h0);
    apb(1'b1, ADDR_CMD, CLR);
    irq_req <= 1'b1;
    apb(1'b1, ADDR_CMD, SLP);
    @(posedge sys_clk);
    chk("nop sleeping", 32'h0, 32'(sleeping));
    irq_req <= 1'b0;
    rdchk("status", ADDR_STATUS, TO_M | PD_M);
    $display("test nop done");
  endtask

  task automatic t_no_wdt_sleep();
    apb(1'b1, ADDR_WDCTL, 32'h0);
    apb(1'b1, ADDR_CFG, 32'(MODE_OFF_SLEEP));
    apb(1'b1, ADDR_CMD, SLP);
    repeat (150) @(posedge sys_clk);
    chk("mode10 asleep", 32'h1, 32'(sleeping));
    irq_req <= 1'b1;
    wait_evt(1'b0, 100, n);
    chk("mode10 wake", 32'h1, 32'(n < 100));
    chk("isr_call", 32'h0, 32'(isr_call));
    irq_req <= 1'b0;
    $display("test no_wdt_sleep done");
  endtask

  task automatic t_sleep_timeout();
    apb(1'b1, ADDR_WDCTL, 32'h1 << WDCTL_PS_LSB);
    apb(1'b1, ADDR_CFG, 32'(MODE_ALWAYS_ON));
    apb(1'b1, ADDR_CMD, SLP);
    wait_evt(1'b0, 300, n);
    chk("sleep wd wake", 32'h1, 32'(n >= 122 && n <= 134));
    rdchk("status", ADDR_STATUS, 32'h0);
    $display("test sleep_timeout done");
  endtask

  task automatic t_awake_timeout();
    osc_fail <= 1'b1;
    wait_evt(1'b1, 150, n);
    chk("osc_fail hold", 32'd150, 32'(n));
    osc_fail <= 1'b0;
    apb(1'b1, ADDR_CMD, CLR);
    wait_evt(1'b1, 300, n);
    chk("awake wd", 32'h1, 32'(n >= 122 && n <= 134));
    rdchk("status", ADDR_STATUS, PD_M);
    do_reset();
    rdchk("wdctl", ADDR_WDCTL, 32'(PS_RESET) << WDCTL_PS_LSB);
    apb(1'b1, ADDR_WDCTL, 32'h0);
    apb(1'b1, ADDR_CFG, 32'(MODE_SOFTWARE));
    wait_evt(1'b1, 150, n);
    chk("swen off", 32'd150, 32'(n));
    apb(1'b1, ADDR_WDCTL, (32'h13 << WDCTL_PS_LSB) | (32'h1 << WDCTL_SWEN));
    wait_evt(1'b1, 300, n);
    chk("swen on", 32'h1, 32'(n >= 58 && n <= 70));
    do_reset();
    $display("test awake_timeout done");
  endtask

  task automatic t_ost();
    apb(1'b1, ADDR_CFG, (32'(OSC_XTAL_MED) << CFG_OSCM_LSB) | (32'h1 << CFG_GIE_BIT));
    apb(1'b1, ADDR_CMD, SLP);
    irq_req <= 1'b1;
    wait_evt(1'b0, 3000, n);
    chk("ost delay", 32'h1, 32'(n >= OST_PERIODS && n <= OST_PERIODS + 16));
    chk("isr_call", 32'h1, 32'(isr_call));
    irq_req <= 1'b0;
    $display("test ost done");
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial
  begin
    {psel, penable, pwrite, osc_fail, irq_req} = '0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    rst    = 1'b1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_irq_wake();
    t_nop();
    t_no_wdt_sleep();
    t_sleep_timeout();
    t_awake_timeout();
    t_ost();
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    give_verdict();
  end
endmodule // swwd_ctrl_tb_top
`default_nettype wire
